// file: design/fdtf_master.sv
// Fieldbus telegram master: builds request telegrams, sends them over the
// half-duplex serial pins, collects and checks the reply, all under APB control.
// Assumes drive_serial_port_rxd is synchronous to pclk and idles high.
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ns
module fdtf_master #(
  parameter logic [31:0] RESP_TIMEOUT_RST = fdtf_pkg::RESP_TIMEOUT_CYC
) (
  input wire logic pclk, // System clock, 25 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic [fdtf_pkg::ADDR_W-1:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [31:0] pwdata, // APB write data
  output logic pready, // APB ready
  output logic [31:0] prdata, // APB read data
  output logic pslverr, // APB error
  input wire logic drive_serial_port_rxd, // Serial receive level
  output logic drive_serial_port_txd, // Serial transmit level
  output logic drive_serial_port_txd_oe // Line driver enable
);

  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_mux;
  logic hit;
  logic wr_fire;
  logic txbuf_sel;
  logic rxbuf_sel;
  logic start_q;
  fdtf_pkg::fdtf_char_cfg_t cfg_q;
  logic [6:0] node_q;
  logic [7:0] txlen_q;
  logic [15:0] baud_div_q;
  logic [31:0] timeout_q;
  fdtf_pkg::fdtf_status_t stat_q;
  fdtf_pkg::fdtf_state_t state_q;
  logic [11:0] tx_sh_q;
  logic oe_q;
  logic [3:0] bit_idx_q;
  logic [15:0] baud_cnt_q;
  logic [7:0] pos_q;
  logic [7:0] bcc_q;
  logic [7:0] adr_q;
  logic [31:0] tout_cnt_q;
  logic [11:0] rx_sh_q;
  logic [7:0] rlen_q;
  logic [7:0] rx_adr_q;
  logic [7:0] tx_byte;
  logic [7:0] tx_mem_q;
  logic [7:0] rx_mem_q;
  logic [7:0] rx_byte;
  logic [3:0] tx_nbits;
  logic [3:0] rx_nbits;
  logic rx_par_bad;
  logic rx_stop_bad;
  logic rx_wr;
  logic [7:0] tx_mem_idx;
  logic [7:0] rx_mem_idx;

  assign pready = pready_q;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign drive_serial_port_txd = tx_sh_q[0];
  assign drive_serial_port_txd_oe = oe_q;

  // Address decode and read mux
  assign txbuf_sel = paddr[fdtf_pkg::ADDR_W-1:fdtf_pkg::BUF_SEL_LSB] ==
                     fdtf_pkg::TXBUF_BASE[fdtf_pkg::ADDR_W-1:fdtf_pkg::BUF_SEL_LSB];
  assign rxbuf_sel = paddr[fdtf_pkg::ADDR_W-1:fdtf_pkg::BUF_SEL_LSB] ==
                     fdtf_pkg::RXBUF_BASE[fdtf_pkg::ADDR_W-1:fdtf_pkg::BUF_SEL_LSB];

  always_comb begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    if (paddr == fdtf_pkg::REG_CTRL) begin
      rd_mux = {28'h0000000, cfg_q, 1'b0};
    end else if (paddr == fdtf_pkg::REG_NODE) begin
      rd_mux = {25'h0000000, node_q};
    end else if (paddr == fdtf_pkg::REG_TXLEN) begin
      rd_mux = {24'h000000, txlen_q};
    end else if (paddr == fdtf_pkg::REG_BAUD) begin
      rd_mux = {16'h0000, baud_div_q};
    end else if (paddr == fdtf_pkg::REG_TIMEOUT) begin
      rd_mux = timeout_q;
    end else if (paddr == fdtf_pkg::REG_STATUS && !pwrite) begin
      rd_mux = {24'h000000, stat_q};
    end else if (paddr == fdtf_pkg::REG_RXINFO && !pwrite) begin
      rd_mux = {16'h0000, rx_adr_q, rlen_q - fdtf_pkg::LEN_OVERHEAD};
    end else if (txbuf_sel && pwrite) begin
      rd_mux = 32'h0000_0000;
    end else if (rxbuf_sel && !pwrite) begin
      rd_mux = {24'h000000, rx_mem_q};
    end else begin
      hit = 1'b0;
    end
  end

  assign wr_fire = psel && penable && pready_q && pwrite && hit;

  // APB handshake: two-cycle access phase so buffer reads settle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (psel && penable && !pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= !hit;
      prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Software configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= 1'b0;
      cfg_q <= '{two_stop: 1'b0, par_odd: 1'b0, par_en: 1'b1};
      node_q <= 7'h00;
      txlen_q <= fdtf_pkg::PROC_LEN;
      baud_div_q <= fdtf_pkg::BAUD_DIV_RST;
      timeout_q <= RESP_TIMEOUT_RST;
    end else begin
      start_q <= wr_fire && paddr == fdtf_pkg::REG_CTRL && pwdata[fdtf_pkg::CTRL_START_BIT];
      if (wr_fire && paddr == fdtf_pkg::REG_CTRL) begin
        cfg_q.par_en <= pwdata[fdtf_pkg::CTRL_PAR_EN_BIT];
        cfg_q.par_odd <= pwdata[fdtf_pkg::CTRL_PAR_ODD_BIT];
        cfg_q.two_stop <= pwdata[fdtf_pkg::CTRL_TWO_STOP_BIT];
      end
      if (wr_fire && paddr == fdtf_pkg::REG_NODE) begin
        node_q <= pwdata[fdtf_pkg::NODE_W-1:0];
      end
      if (wr_fire && paddr == fdtf_pkg::REG_TXLEN) begin
        txlen_q <= pwdata[7:0];
      end
      if (wr_fire && paddr == fdtf_pkg::REG_BAUD) begin
        baud_div_q <= pwdata[15:0];
      end
      if (wr_fire && paddr == fdtf_pkg::REG_TIMEOUT) begin
        timeout_q <= pwdata;
      end
    end
  end

  assign tx_mem_idx = pos_q - fdtf_pkg::HDR_BYTES;
  assign rx_mem_idx = pos_q - fdtf_pkg::HDR_BYTES;

  fdtf_buf_mem u_tx_mem (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_fire && txbuf_sel),
    .wr_addr(paddr[fdtf_pkg::WORD_LSB+fdtf_pkg::MEM_AW-1:fdtf_pkg::WORD_LSB]),
    .wr_data(pwdata[7:0]),
    .rd_addr(tx_mem_idx[fdtf_pkg::MEM_AW-1:0]),
    .rd_data_q(tx_mem_q)
  );

  fdtf_buf_mem u_rx_mem (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(rx_wr),
    .wr_addr(rx_mem_idx[fdtf_pkg::MEM_AW-1:0]),
    .wr_data(rx_byte),
    .rd_addr(paddr[fdtf_pkg::WORD_LSB+fdtf_pkg::MEM_AW-1:fdtf_pkg::WORD_LSB]),
    .rd_data_q(rx_mem_q)
  );

  assign tx_nbits = fdtf_pkg::CHAR_BASE_BITS + {3'b000, cfg_q.par_en} + {3'b000, cfg_q.two_stop};
  assign rx_nbits = fdtf_pkg::CHAR_BASE_BITS + {3'b000, cfg_q.par_en};

  always_comb begin
    tx_byte = tx_mem_q;
    if (pos_q == 8'h00) begin
      tx_byte = fdtf_pkg::STX_CHAR;
    end else if (pos_q == fdtf_pkg::POS_LGE) begin
      tx_byte = txlen_q + fdtf_pkg::LEN_OVERHEAD;
    end else if (pos_q == fdtf_pkg::POS_ADR) begin
      tx_byte = adr_q;
    end else if (pos_q == txlen_q + fdtf_pkg::HDR_BYTES) begin
      tx_byte = bcc_q;
    end
  end

  assign rx_byte = rx_sh_q[8:1];
  // even or odd parity check over data and parity, chosen by par_odd
  assign rx_par_bad = cfg_q.par_en && ((^rx_sh_q[fdtf_pkg::PAR_POS:1]) != cfg_q.par_odd);
  assign rx_stop_bad = !rx_sh_q[rx_nbits - 4'h1];
  assign rx_wr = state_q == fdtf_pkg::ST_RX_NEXT && !rx_par_bad && !rx_stop_bad &&
                 pos_q >= fdtf_pkg::HDR_BYTES && pos_q <= rlen_q;

  // Telegram sequencer and serial engine
  // sole master starts transfers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= fdtf_pkg::ST_IDLE;
      stat_q <= '0;
      tx_sh_q <= '1;
      oe_q <= 1'b0;
      bit_idx_q <= 4'h0;
      baud_cnt_q <= 16'h0000;
      pos_q <= 8'h00;
      bcc_q <= 8'h00;
      adr_q <= 8'h00;
      tout_cnt_q <= 32'h0000_0000;
      rx_sh_q <= '1;
      rlen_q <= fdtf_pkg::LEN_OVERHEAD;
      rx_adr_q <= 8'h00;
    end else begin
      case (state_q)
        fdtf_pkg::ST_IDLE: begin
          if (start_q) begin
            stat_q <= '{busy: 1'b1, default: 1'b0};
            pos_q <= 8'h00;
            bcc_q <= 8'h00;
            rlen_q <= fdtf_pkg::LEN_OVERHEAD;
            // address format bit with node number
            adr_q <= fdtf_pkg::ADDR_FMT | {1'b0, node_q};
            if (txlen_q > fdtf_pkg::MEM_DEPTH) begin
              stat_q.len_err <= 1'b1;
              state_q <= fdtf_pkg::ST_DONE;
            end else begin
              state_q <= fdtf_pkg::ST_TX_NEXT;
            end
          end
        end
        fdtf_pkg::ST_TX_NEXT: begin
          if (pos_q > txlen_q + fdtf_pkg::HDR_BYTES) begin
            // release the line after the request
            oe_q <= 1'b0;
            pos_q <= 8'h00;
            bcc_q <= 8'h00;
            tout_cnt_q <= timeout_q;
            state_q <= (adr_q[6:0] == fdtf_pkg::NODE_BCAST) ? fdtf_pkg::ST_DONE : fdtf_pkg::ST_RX_WAIT;
          end else begin
            oe_q <= 1'b1;
            tx_sh_q <= {2'b11, cfg_q.par_en ? (^tx_byte ^ cfg_q.par_odd) : 1'b1, tx_byte, 1'b0};
            bcc_q <= bcc_q ^ tx_byte;
            pos_q <= pos_q + 8'h01;
            bit_idx_q <= 4'h0;
            baud_cnt_q <= baud_div_q - 16'h0001;
            state_q <= fdtf_pkg::ST_TX_BIT;
          end
        end
        fdtf_pkg::ST_TX_BIT: begin
          if (baud_cnt_q != 16'h0000) begin
            baud_cnt_q <= baud_cnt_q - 16'h0001;
          end else if (bit_idx_q == tx_nbits - 4'h1) begin
            tx_sh_q <= '1;
            state_q <= fdtf_pkg::ST_TX_NEXT;
          end else begin
            tx_sh_q <= {1'b1, tx_sh_q[11:1]};
            bit_idx_q <= bit_idx_q + 4'h1;
            baud_cnt_q <= baud_div_q - 16'h0001;
          end
        end
        fdtf_pkg::ST_RX_WAIT: begin
          if (tout_cnt_q == 32'h0000_0000) begin
            // reply too late counts as missing
            stat_q.timeout <= 1'b1;
            state_q <= fdtf_pkg::ST_DONE;
          end else if (!drive_serial_port_rxd) begin
            bit_idx_q <= 4'h0;
            baud_cnt_q <= {1'b0, baud_div_q[15:1]};
            state_q <= fdtf_pkg::ST_RX_BIT;
          end else begin
            tout_cnt_q <= tout_cnt_q - 32'h0000_0001;
          end
        end
        fdtf_pkg::ST_RX_BIT: begin
          if (baud_cnt_q != 16'h0000) begin
            baud_cnt_q <= baud_cnt_q - 16'h0001;
          end else if (bit_idx_q == 4'h0 && drive_serial_port_rxd) begin
            state_q <= fdtf_pkg::ST_RX_WAIT;
          end else begin
            rx_sh_q[bit_idx_q] <= drive_serial_port_rxd;
            bit_idx_q <= bit_idx_q + 4'h1;
            baud_cnt_q <= baud_div_q - 16'h0001;
            if (bit_idx_q == rx_nbits - 4'h1) begin
              state_q <= fdtf_pkg::ST_RX_NEXT;
            end
          end
        end
        fdtf_pkg::ST_RX_NEXT: begin
          bcc_q <= bcc_q ^ rx_byte;
          pos_q <= pos_q + 8'h01;
          tout_cnt_q <= timeout_q;
          state_q <= fdtf_pkg::ST_RX_WAIT;
          if (rx_par_bad) begin
            stat_q.parity_err <= 1'b1;
            state_q <= fdtf_pkg::ST_DONE;
          end else if (rx_stop_bad || (pos_q == 8'h00 && rx_byte != fdtf_pkg::STX_CHAR)) begin
            stat_q.frame_err <= 1'b1;
            state_q <= fdtf_pkg::ST_DONE;
          end else if (pos_q == fdtf_pkg::POS_LGE) begin
            rlen_q <= rx_byte;
            if (rx_byte < fdtf_pkg::LEN_OVERHEAD || rx_byte - fdtf_pkg::LEN_OVERHEAD > fdtf_pkg::MEM_DEPTH) begin
              stat_q.len_err <= 1'b1;
              state_q <= fdtf_pkg::ST_DONE;
            end
          end else if (pos_q == fdtf_pkg::POS_ADR) begin
            rx_adr_q <= rx_byte;
            // only the polled node may answer
            if (rx_byte != adr_q) begin
              stat_q.addr_err <= 1'b1;
              state_q <= fdtf_pkg::ST_DONE;
            end
          end else if (pos_q == rlen_q + 8'h01) begin
            state_q <= fdtf_pkg::ST_DONE;
            // XOR over whole telegram is zero
            if ((bcc_q ^ rx_byte) != 8'h00) begin
              stat_q.check_err <= 1'b1;
            end else if ((txlen_q == fdtf_pkg::PROC_LEN || txlen_q == fdtf_pkg::PARAM_LEN) &&
                         rlen_q != txlen_q + fdtf_pkg::LEN_OVERHEAD) begin
              stat_q.len_err <= 1'b1;
            // text reply holds its fixed part
            end else if (txlen_q != fdtf_pkg::PROC_LEN && txlen_q != fdtf_pkg::PARAM_LEN &&
                         rlen_q < fdtf_pkg::TEXT_FIXED) begin
              stat_q.len_err <= 1'b1;
            end
          end
        end
        fdtf_pkg::ST_DONE: begin
          oe_q <= 1'b0;
          stat_q.busy <= 1'b0;
          stat_q.done <= 1'b1;
          state_q <= fdtf_pkg::ST_IDLE;
        end
        default: begin
          state_q <= fdtf_pkg::ST_IDLE;
        end
      endcase
    end
  end

endmodule

// file: design/fdtf_pkg.sv
// Constants, field layouts and types for the fieldbus telegram master.
// Assumes a 25 MHz pclk and software access over a 32-bit APB slave port.
package fdtf_pkg;

  // Clock and default link timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned BAUD_DEFAULT = 9600;
  localparam int unsigned BAUD_MIN = 2400;
  localparam int unsigned BAUD_MAX = 115200;
  localparam logic [15:0] BAUD_DIV_RST = 16'(CLK_HZ / BAUD_DEFAULT);
  localparam int unsigned RESP_TIMEOUT_MS = 50;
  localparam logic [31:0] RESP_TIMEOUT_CYC = 32'(CLK_HZ / 1000 * RESP_TIMEOUT_MS);

  // APB register map, byte addresses
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_NODE = 12'h004;
  localparam logic [11:0] REG_TXLEN = 12'h008;
  localparam logic [11:0] REG_BAUD = 12'h00c;
  localparam logic [11:0] REG_TIMEOUT = 12'h010;
  localparam logic [11:0] REG_STATUS = 12'h014;
  localparam logic [11:0] REG_RXINFO = 12'h018;
  localparam logic [11:0] TXBUF_BASE = 12'h100;
  localparam logic [11:0] RXBUF_BASE = 12'h200;
  localparam int unsigned BUF_SEL_LSB = 7;
  localparam int unsigned WORD_LSB = 2;

  // Control register fields
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_PAR_EN_BIT = 1;
  localparam int unsigned CTRL_PAR_ODD_BIT = 2;
  localparam int unsigned CTRL_TWO_STOP_BIT = 3;
  localparam int unsigned NODE_W = 7;

  // Character framing
  localparam logic [3:0] CHAR_BASE_BITS = 4'ha;
  localparam int unsigned FRAME_W = 12;
  localparam int unsigned PAR_POS = 9;

  // Telegram framing
  localparam logic [7:0] STX_CHAR = 8'h02;
  localparam logic [7:0] LEN_OVERHEAD = 8'h02;
  localparam logic [7:0] ADDR_FMT = 8'h80;
  localparam logic [7:0] HDR_BYTES = 8'h03;
  localparam logic [7:0] PROC_LEN = 8'h04;
  localparam logic [7:0] PARAM_LEN = 8'h0c;
  localparam logic [7:0] TEXT_FIXED = 8'h0a;
  localparam logic [7:0] POS_LGE = 8'h01;
  localparam logic [7:0] POS_ADR = 8'h02;
  localparam logic [6:0] NODE_BCAST = 7'h00;

  // Telegram buffers
  localparam int unsigned MEM_AW = 5;
  localparam logic [7:0] MEM_DEPTH = 8'h20;

  typedef struct packed {
    logic two_stop;
    logic par_odd;
    logic par_en;
  } fdtf_char_cfg_t;

  typedef struct packed {
    logic check_err;
    logic len_err;
    logic addr_err;
    logic frame_err;
    logic parity_err;
    logic timeout;
    logic done;
    logic busy;
  } fdtf_status_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_TX_NEXT = 3'b001,
    ST_TX_BIT  = 3'b011,
    ST_RX_WAIT = 3'b010,
    ST_RX_BIT  = 3'b110,
    ST_RX_NEXT = 3'b111,
    ST_DONE    = 3'b101
  } fdtf_state_t;

endpackage

// file: design/fdtf_buf_mem.sv
// Byte buffer for one telegram, one write port and a registered read port.
// Assumes both ports run on pclk; read data appear one edge after the address.
`timescale 1ns/1ns
module fdtf_buf_mem (
  input wire logic pclk, // System clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic wr_en, // Write strobe
  input wire logic [fdtf_pkg::MEM_AW-1:0] wr_addr, // Write index
  input wire logic [7:0] wr_data, // Write byte
  input wire logic [fdtf_pkg::MEM_AW-1:0] rd_addr, // Read index
  output logic [7:0] rd_data_q // Registered read byte
);

  logic [7:0] mem [0:(1 << fdtf_pkg::MEM_AW)-1];

  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data_q <= 8'h00;
    end else begin
      rd_data_q <= mem[rd_addr];
    end
  end

endmodule

// file: verification/fdtf_master_asserts.sv
// Concurrent checks on the telegram master's APB and serial pins.
// Assumes one pclk domain and the register map of fdtf_pkg.
`timescale 1ns/1ns
module fdtf_master_asserts #(
  parameter logic [31:0] RESP_TIMEOUT_RST = 32'h0000_07d0
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic [fdtf_pkg::ADDR_W-1:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [31:0] pwdata, // APB write data
  input wire logic pready, // APB ready
  input wire logic [31:0] prdata, // APB read data
  input wire logic pslverr, // APB error
  input wire logic drive_serial_port_rxd, // Serial receive
  input wire logic drive_serial_port_txd, // Serial transmit
  input wire logic drive_serial_port_txd_oe // Driver enable
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    !pready ##1 (pready && psel && penable);
  endsequence
  chk_apb_latency:
    assert property (s_setup |=> s_answer) else $error("APB answer not in second access cycle");
  chk_ready_pulse:
    assert property (pready |=> !pready) else $error("pready longer than one cycle");
  chk_err_qualified:
    assert property (pslverr |-> pready) else $error("pslverr without pready");
  chk_ro_write_err:
    assert property (pready && pwrite && (paddr == fdtf_pkg::REG_STATUS || paddr == fdtf_pkg::REG_RXINFO)
      |-> pslverr) else $error("write to read-only register accepted");
  chk_unmapped_err:
    assert property (pready && paddr == 12'h01c |-> pslverr) else $error("unmapped access accepted");
  chk_start_reads_zero:
    assert property (pready && !pwrite && paddr == fdtf_pkg::REG_CTRL |-> !prdata[0] && !pslverr)
      else $error("start bit reads back set");
  chk_line_listen:
    assert property (!drive_serial_port_txd_oe |-> drive_serial_port_txd) else $error("txd low while released");
  chk_oe_start_bit:
    assert property ($rose(drive_serial_port_txd_oe) |-> !drive_serial_port_txd ##1 !drive_serial_port_txd)
      else $error("request does not open with a start bit");
  chk_oe_after_stop:
    assert property ($fell(drive_serial_port_txd_oe) |-> drive_serial_port_txd && $past(drive_serial_port_txd))
      else $error("driver released before stop bit");
endmodule

bind fdtf_master fdtf_master_asserts #(.RESP_TIMEOUT_RST(RESP_TIMEOUT_RST)) u_fdtf_master_asserts (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .drive_serial_port_rxd(drive_serial_port_rxd), .drive_serial_port_txd(drive_serial_port_txd),
  .drive_serial_port_txd_oe(drive_serial_port_txd_oe));

// file: verification/fdtf_slave_model.sv
// Behavioural drive node: parses requests on txd and answers on rxd.
// Assumes even parity, one stop bit and BIT_CYC pclk cycles per bit.
`timescale 1ns/1ns
module fdtf_slave_model #(
  parameter int BIT_CYC = 8
) (
  input wire logic pclk, // Clock
  input wire logic txd, // Request line from master
  input wire logic txd_oe, // Master driver enable
  input wire logic [6:0] node, // Own node address
  input wire logic [15:0] gap, // Reply delay in cycles
  input wire logic bad_chk, // Corrupt reply check byte
  output logic rxd, // Reply line, idles high by bias
  output int n_good // Well-formed requests seen
);
  logic [7:0] stx, len, adr, x, x_tx;
  logic [7:0] dat[64];
  logic ok, o, good;

  task automatic rx_char(output logic [7:0] b, output logic k);
    logic p;
    while (!(txd_oe === 1'b1 && txd === 1'b0)) @(posedge pclk);
    repeat (BIT_CYC / 2) @(posedge pclk);
    k = (txd === 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge pclk);
      b[i] = txd;
    end
    repeat (BIT_CYC) @(posedge pclk);
    p = txd;
    repeat (BIT_CYC) @(posedge pclk);
    k = k && (^{b, p} === 1'b0) && (txd === 1'b1) && (txd_oe === 1'b1);
  endtask

  task automatic tx_char(input logic [7:0] b);
    logic [10:0] f;
    f = {1'b1, ^b, b, 1'b0};
    x_tx = x_tx ^ b;
    for (int i = 0; i < 11; i++) begin
      rxd <= f[i];
      repeat (BIT_CYC) @(posedge pclk);
    end
  endtask

  initial begin
    rxd = 1'b1;
    n_good = 0;
    forever begin
      rx_char(stx, ok);
      rx_char(len, o);
      ok = ok & o;
      rx_char(adr, o);
      ok = ok & o;
      x = stx ^ len ^ adr;
      if (len >= 8'h02 && len < 8'h3c) begin
        for (int i = 0; i < int'(len) - 1; i++) begin
          rx_char(dat[i], o);
          ok = ok & o;
          x = x ^ dat[i];
        end
      end else begin
        ok = 1'b0;
      end
      good = ok && stx == 8'h02 && adr[7] && x == 8'h00;
      if (good) begin
        n_good++;
      end
      if (good && adr[6:0] != 7'h00 && adr[6:0] == node) begin
        while (txd_oe !== 1'b0) @(posedge pclk);
        repeat (gap) @(posedge pclk);
        x_tx = 8'h00;
        tx_char(8'h02);
        tx_char(len);
        tx_char(adr);
        for (int i = 0; i < int'(len) - 2; i++) begin
          tx_char(~dat[i]);
        end
        tx_char(x_tx ^ {7'h00, bad_chk});
      end
    end
  end
endmodule

// file: verification/fdtf_master_test.sv
// Self-checking bench for the telegram master with one drive node model.
// Assumes the APB map of fdtf_pkg and a 25 MHz pclk.
`timescale 1ns/1ns
`define CHK(nm, got, exp) begin n_compared++; if ((got) !== (exp)) begin n_errors++; \
  $display("Error %s expected %h seen %h", nm, (exp), (got)); end end
module fdtf_master_test;
  typedef struct packed {logic err; logic [31:0] mask; logic [31:0] val;} fdtf_exp_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic pready, pslverr, rxd, txd, txd_oe;
  logic [31:0] prdata, rd;
  logic [6:0] sl_node = 7'h03;
  logic [15:0] sl_gap = 16'h0010;
  logic sl_bad = 1'b0;
  int n_good, n_errors = 0, n_compared = 0;
  fdtf_exp_t exp_q[$];
  fdtf_exp_t mon_e;
  logic [31:0] lfsr = 32'he953;
  logic [7:0] tx_d[32];

  always #20 pclk = ~pclk;

  fdtf_master #(.RESP_TIMEOUT_RST(32'h0000_07d0)) u_fdtf_master (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .drive_serial_port_rxd(rxd), .drive_serial_port_txd(txd),
    .drive_serial_port_txd_oe(txd_oe));
  fdtf_slave_model #(.BIT_CYC(8)) u_fdtf_slave_model (.pclk(pclk), .txd(txd), .txd_oe(txd_oe),
    .node(sl_node), .gap(sl_gap), .bad_chk(sl_bad), .rxd(rxd), .n_good(n_good));

  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
                     input logic [31:0] e, input logic err);
    int k;
    exp_q.push_back(fdtf_exp_t'({err, m, e}));
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      n_errors++;
      test_done();
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0, m, e, 1'b0);
  endtask

  // Sends one request and checks status and reply contents
  task automatic run_frame(input logic [6:0] nd, input logic [7:0] n, input logic [7:0] st, input logic rep);
    int k;
    for (int i = 0; i < 32; i++) begin
      lfsr = lfsr_step(lfsr);
      tx_d[i] = lfsr[7:0];
      if (i < n) wr(fdtf_pkg::TXBUF_BASE + 12'(4 * i), {24'h0, tx_d[i]});
    end
    wr(fdtf_pkg::REG_TXLEN, {24'h0, n});
    wr(fdtf_pkg::REG_NODE, {25'h0, nd});
    wr(fdtf_pkg::REG_BAUD, 32'h8);
    wr(fdtf_pkg::REG_CTRL, 32'h3);
    k = 0;
    do begin
      apb(1'b0, fdtf_pkg::REG_STATUS, 32'h0, 32'h0, 32'h0, 1'b0);
      k++;
    end while (rd[1:0] !== 2'b10 && k < 2000);
    if (rd[1:0] !== 2'b10) begin
      n_errors++;
      test_done();
    end
    rd_chk(fdtf_pkg::REG_STATUS, 32'hff, {24'h0, st});
    if (rep) begin
      rd_chk(fdtf_pkg::REG_RXINFO, 32'hffff, {16'h0, 1'b1, nd, n});
      for (int i = 0; i < n; i++) begin
        rd_chk(fdtf_pkg::RXBUF_BASE + 12'(4 * i), 32'hff, {24'h0, ~tx_d[i]});
      end
    end
  endtask

  // Every APB answer is matched against the oldest expectation
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("Error pready expected 0 seen 1");
      end else begin
        mon_e = exp_q.pop_front();
        `CHK("pslverr", pslverr, mon_e.err)
        `CHK("prdata", prdata & mon_e.mask, mon_e.val)
      end
    end
  end

  initial begin
    repeat (100000) @(posedge pclk);
    n_errors++;
    test_done();
  end

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(fdtf_pkg::REG_CTRL, 32'hf, 32'h2);
    rd_chk(fdtf_pkg::REG_NODE, 32'h7f, 32'h0);
    rd_chk(fdtf_pkg::REG_TXLEN, 32'hff, 32'h4);
    rd_chk(fdtf_pkg::REG_BAUD, 32'hffff, 32'h0a2c);
    rd_chk(fdtf_pkg::REG_TIMEOUT, 32'hffffffff, 32'h7d0);
    wr(fdtf_pkg::REG_CTRL, 32'he);
    rd_chk(fdtf_pkg::REG_CTRL, 32'hf, 32'he);
    apb(1'b1, fdtf_pkg::REG_STATUS, 32'hff, 32'h0, 32'h0, 1'b1);
    apb(1'b0, fdtf_pkg::TXBUF_BASE, 32'h0, 32'h0, 32'h0, 1'b1);
    apb(1'b0, 12'h01c, 32'h0, 32'h0, 32'h0, 1'b1);
    $display("Test registers finished");
    run_frame(7'h03, 8'h04, 8'h02, 1'b1);
    sl_gap <= 16'h012c;
    run_frame(7'h03, 8'h0c, 8'h02, 1'b1);
    sl_gap <= 16'h0010;
    run_frame(7'h03, 8'h0d, 8'h02, 1'b1);
    $display("Test formats finished");
    run_frame(7'h00, 8'h04, 8'h02, 1'b0);
    run_frame(7'h05, 8'h04, 8'h06, 1'b0);
    sl_bad <= 1'b1;
    run_frame(7'h03, 8'h04, 8'h82, 1'b0);
    sl_bad <= 1'b0;
    run_frame(7'h03, 8'h21, 8'h42, 1'b0);
    `CHK("n_good", n_good, 6)
    $display("Test faults finished");
    test_done();
  end
endmodule
